// ==== design/rtt_params.svh ====
// Purpose: constants for the transmit/receive timing timers
// Assumes: 50 MHz system clock; register word index times four is the byte address
// Notes: definitions only
`ifndef RTT_PARAMS_SVH
`define RTT_PARAMS_SVH

// ----------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define RTT_IDX_PROTO 4'h1
`define RTT_IDX_TMHI 4'h4
`define RTT_IDX_TMLO 4'h5
`define RTT_IDX_PW 4'h6
`define RTT_IDX_NR 4'h7
`define RTT_IDX_IGN 4'h8
`define RTT_IDX_STATUS 4'hC

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RTT_PROTO_RST 5'h02
`define RTT_TMHI_RST 8'hC2
`define RTT_TMLO_RST 8'h00
`define RTT_PW_RST 8'h00
`define RTT_NR_RST 8'h0E
`define RTT_IGN_RST 8'h1F

// ----------------------------------------------------------------
// field positions in the delay timer high byte
// ----------------------------------------------------------------
`define RTT_SEL_HI 7
`define RTT_SEL_LO 6
`define RTT_LEN_MSB 5

// ----------------------------------------------------------------
// protocol codes and per-protocol preset codes
// ----------------------------------------------------------------
`define RTT_PROTO_TAG 5'h13
`define RTT_PROTO_A106 5'h08
`define RTT_PROTO_A212 5'h09
`define RTT_PROTO_A424 5'h0A
`define RTT_PROTO_A848 5'h0B
`define RTT_PW_VIC 8'h80
`define RTT_PW_TAG 8'h95
`define RTT_PW_A106 8'h20
`define RTT_PW_A212 8'h13
`define RTT_PW_A424 8'h0A
`define RTT_PW_A848 8'h06
`define RTT_NR_VIC 8'h14
`define RTT_NR_VIC_LOW 8'h30
`define RTT_NR_TAG 8'h10
`define RTT_IGN_VIC 8'h1F
`define RTT_IGN_PROX 8'h07
`define RTT_IGN_TAG 8'h13

// ----------------------------------------------------------------
// timing: step sizes in ps and derived step lengths in clock cycles
// ----------------------------------------------------------------
`define RTT_CLK_PS 20000
`define RTT_DLY_STEP_PS 590000
`define RTT_PW_STEP_PS 73700
`define RTT_NR_STEP_PS 37760000
`define RTT_IGN_STEP_PS 9440000
`define RTT_DLY_STEP_CYC (`RTT_DLY_STEP_PS / `RTT_CLK_PS)
`define RTT_PW_STEP_CYC (`RTT_PW_STEP_PS / `RTT_CLK_PS)
`define RTT_NR_STEP_CYC (`RTT_NR_STEP_PS / `RTT_CLK_PS)
`define RTT_IGN_STEP_CYC (`RTT_IGN_STEP_PS / `RTT_CLK_PS)

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define RTT_RESP_OKAY 2'h0
`define RTT_RESP_SLVERR 2'h2

`endif

// ==== design/rtt_pkg.sv ====
// Purpose: state types for the timing timers
// Assumes: widths fixed at the documented values
// Notes: no constants here; those live in rtt_params.svh
package rtt_pkg;

  // one step timer: 14-bit step count, 11-bit cycle prescaler
  typedef struct packed {
    logic busy;
    logic expire;
    logic [13:0] steps;
    logic [10:0] pre;
  } rtt_tmr_t;

  // whole top-level state
  typedef struct packed {
    logic en_s1;
    logic en_s2;
    logic [4:0] proto;
    logic [7:0] tm_hi;
    logic [7:0] tm_lo;
    logic [7:0] pw;
    logic [7:0] nr;
    logic [7:0] ign;
    logic awready;
    logic wready;
    logic aw_full;
    logic w_full;
    logic [3:0] aw_idx;
    logic [7:0] wdata;
    logic wstb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic tx_pulse;
  } rtt_top_t;

endpackage

// ==== design/rtt_step_timer.sv ====
// Purpose: counts a programmed number of fixed-length steps after a start
// Assumes: start and stop come from logic on clk
// Notes: a count of zero leaves the timer idle
`timescale 1ns/1ps
`include "rtt_params.svh"

module rtt_step_timer #(
  parameter logic [10:0] STEP_CYC = 11'h001
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic stop,
  input wire logic [13:0] count,
  output logic busy,
  output logic expire
);

  rtt_pkg::rtt_tmr_t s;      // registered state
  rtt_pkg::rtt_tmr_t next_s; // next state

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.expire = 1'b0;
    if (stop) begin
      // abort wins over everything
      next_s.busy = 1'b0;
    end else if (start && count != 14'h0000) begin
      next_s.busy = 1'b1;
      next_s.steps = count;
      next_s.pre = STEP_CYC - 11'h001;
    end else if (s.busy) begin
      if (s.pre == 11'h000) begin
        if (s.steps == 14'h0001) begin
          next_s.busy = 1'b0;
          next_s.expire = 1'b1;
        end else begin
          next_s.steps = s.steps - 14'h0001;
          next_s.pre = STEP_CYC - 11'h001;
        end
      end else begin
        next_s.pre = s.pre - 11'h001;
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign busy = s.busy;
  assign expire = s.expire;

  AST_ZERO_COUNT_IDLE: assert property (@(posedge clk) disable iff (srst)
    (start && count == 14'h0000 && !s.busy && !stop) |=> !busy)
    else $error("timer started with zero count");

  AST_EXPIRE_ONCE: assert property (@(posedge clk) disable iff (srst)
    expire |-> (!busy ##1 !expire))
    else $error("expiry not a single pulse");

endmodule // rtt_step_timer

// ==== design/rtt_timing_top.sv ====
// Purpose: transmit delay, pulse length, no-reply and receive-ignore timers
// Assumes: frame event inputs are one-cycle pulses from framing logic on clk
// Notes: registers over AXI4-Lite, byte address = 4 * index
`timescale 1ns/1ps
`include "rtt_params.svh"

module rtt_timing_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic en,
  input wire logic tx_sof_begin,
  input wire logic tx_sof_end,
  input wire logic rx_sof_begin,
  input wire logic rx_sof_end,
  input wire logic tx_eof_end,
  input wire logic rx_response_start,
  input wire logic tx_pulse_req,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [4:0] protocol_sel,
  output logic tx_delay_go,
  output logic tx_pulse,
  output logic no_reply_irq,
  output logic rx_ignore
);

  // ----------------------------------------------------------------
  // preset lookup
  // ----------------------------------------------------------------

  // protocol picks presets
  // returns {pulse width, no reply, receive ignore}
  function automatic logic [23:0] rtt_presets(input logic [4:0] p);
    logic [7:0] pwv;
    logic [7:0] nrv;
    logic [7:0] igv;
    pwv = `RTT_PW_RST;
    nrv = `RTT_NR_RST;
    igv = `RTT_IGN_RST;
    if (p[4:3] == 2'h0) begin
      pwv = `RTT_PW_VIC;
      igv = `RTT_IGN_VIC;
      nrv = p[1] ? `RTT_NR_VIC : `RTT_NR_VIC_LOW;
    end else if (p[4:3] == 2'h1) begin
      igv = `RTT_IGN_PROX;
      if (p == `RTT_PROTO_A106) begin
        pwv = `RTT_PW_A106;
      end else if (p == `RTT_PROTO_A212) begin
        pwv = `RTT_PW_A212;
      end else if (p == `RTT_PROTO_A424) begin
        pwv = `RTT_PW_A424;
      end else if (p == `RTT_PROTO_A848) begin
        pwv = `RTT_PW_A848;
      end
    end else if (p == `RTT_PROTO_TAG) begin
      pwv = `RTT_PW_TAG;
      nrv = `RTT_NR_TAG;
      igv = `RTT_IGN_TAG;
    end
    return {pwv, nrv, igv};
  endfunction

  // ----------------------------------------------------------------
  // state and internal nets
  // ----------------------------------------------------------------
  rtt_pkg::rtt_top_t s;      // registered state
  rtt_pkg::rtt_top_t next_s; // next state
  logic do_write;            // both write halves captured, no response pending
  logic proto_wr;            // protocol register written this cycle
  logic clear_all;           // enable low or protocol write
  logic dly_start;           // selected start event
  logic [13:0] dly_count;    // full delay length
  logic [23:0] preset;       // presets of the incoming protocol
  logic [3:0] ar_idx;        // read word index
  logic dly_busy;            // delay timer running
  logic pw_busy;             // pulse timer running
  logic nr_busy;             // no reply timer running

  // ----------------------------------------------------------------
  // control decode
  // ----------------------------------------------------------------
  always_comb begin
    do_write = s.aw_full && s.w_full && !s.bvalid;
    proto_wr = do_write && s.wstb && s.aw_idx == `RTT_IDX_PROTO;
    clear_all = !s.en_s2 || proto_wr;
    dly_count = {s.tm_hi[`RTT_LEN_MSB:0], s.tm_lo};
    case (s.tm_hi[`RTT_SEL_HI:`RTT_SEL_LO])
      2'h0: dly_start = tx_sof_begin;
      2'h1: dly_start = tx_sof_end;
      2'h2: dly_start = rx_sof_begin;
      default: dly_start = rx_sof_end;
    endcase
    preset = rtt_presets(s.wdata[4:0]);
    ar_idx = s_axi_araddr[5:2];
  end

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------

  rtt_step_timer #(
    .STEP_CYC(11'(`RTT_DLY_STEP_CYC))
  ) u_delay (
    .clk(clk),
    .srst(srst),
    .start(dly_start),
    .stop(clear_all),
    .count(dly_count),
    .busy(dly_busy),
    .expire(tx_delay_go)
  );

  rtt_step_timer #(
    .STEP_CYC(11'(`RTT_PW_STEP_CYC))
  ) u_pulse (
    .clk(clk),
    .srst(srst),
    .start(tx_pulse_req),
    .stop(clear_all),
    .count({6'h00, s.pw}),
    .busy(pw_busy),
    .expire()
  );

  rtt_step_timer #(
    .STEP_CYC(11'(`RTT_NR_STEP_CYC))
  ) u_noreply (
    .clk(clk),
    .srst(srst),
    .start(tx_eof_end),
    .stop(clear_all || rx_response_start),
    .count({6'h00, s.nr}),
    .busy(nr_busy),
    .expire(no_reply_irq)
  );

  rtt_step_timer #(
    .STEP_CYC(11'(`RTT_IGN_STEP_CYC))
  ) u_ignore (
    .clk(clk),
    .srst(srst),
    .start(tx_eof_end),
    .stop(clear_all),
    .count({6'h00, s.ign}),
    .busy(rx_ignore),
    .expire()
  );

  // ----------------------------------------------------------------
  // next state: sync, registers, bus
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    // enable pin through two flops
    next_s.en_s1 = en;
    next_s.en_s2 = s.en_s1;
    next_s.tx_pulse = (s.pw == 8'h00) ? tx_pulse_req : pw_busy;

    // write address channel
    if (s_axi_awvalid && s.awready) begin
      next_s.awready = 1'b0;
      next_s.aw_full = 1'b1;
      next_s.aw_idx = s_axi_awaddr[5:2];
    end
    // write data channel, only the low byte is stored
    if (s_axi_wvalid && s.wready) begin
      next_s.wready = 1'b0;
      next_s.w_full = 1'b1;
      next_s.wdata = s_axi_wdata[7:0];
      next_s.wstb = s_axi_wstrb[0];
    end

    // perform the write once both halves are in
    if (do_write) begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `RTT_RESP_OKAY;
      if (s.aw_idx == `RTT_IDX_PROTO) begin
        if (s.wstb) begin
          next_s.proto = s.wdata[4:0];
        end
      end else if (s.aw_idx == `RTT_IDX_TMHI) begin
        if (s.wstb) begin
          next_s.tm_hi = s.wdata;
        end
      end else if (s.aw_idx == `RTT_IDX_TMLO) begin
        if (s.wstb) begin
          next_s.tm_lo = s.wdata;
        end
      end else if (s.aw_idx == `RTT_IDX_PW) begin
        if (s.wstb) begin
          next_s.pw = s.wdata;
        end
      end else if (s.aw_idx == `RTT_IDX_NR) begin
        if (s.wstb) begin
          next_s.nr = s.wdata;
        end
      end else if (s.aw_idx == `RTT_IDX_IGN) begin
        if (s.wstb) begin
          next_s.ign = s.wdata;
        end
      end else if (s.aw_idx != `RTT_IDX_STATUS) begin
        // unmapped word
        next_s.bresp = `RTT_RESP_SLVERR;
      end
    end
    // write response taken, reopen both channels
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end

    if (proto_wr) begin
      next_s.tm_hi = `RTT_TMHI_RST;
      next_s.tm_lo = `RTT_TMLO_RST;
      next_s.pw = preset[23:16];
      next_s.nr = preset[15:8];
      next_s.ign = preset[7:0];
    end
    if (!s.en_s2) begin
      next_s.proto = `RTT_PROTO_RST;
      next_s.tm_hi = `RTT_TMHI_RST;
      next_s.tm_lo = `RTT_TMLO_RST;
      next_s.pw = `RTT_PW_RST;
      next_s.nr = `RTT_NR_RST;
      next_s.ign = `RTT_IGN_RST;
    end

    // read channel, one-cycle answer
    if (s_axi_arvalid && s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = `RTT_RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      if (ar_idx == `RTT_IDX_PROTO) begin
        next_s.rdata[4:0] = s.proto;
      end else if (ar_idx == `RTT_IDX_TMHI) begin
        next_s.rdata[7:0] = s.tm_hi;
      end else if (ar_idx == `RTT_IDX_TMLO) begin
        next_s.rdata[7:0] = s.tm_lo;
      end else if (ar_idx == `RTT_IDX_PW) begin
        next_s.rdata[7:0] = s.pw;
      end else if (ar_idx == `RTT_IDX_NR) begin
        next_s.rdata[7:0] = s.nr;
      end else if (ar_idx == `RTT_IDX_IGN) begin
        next_s.rdata[7:0] = s.ign;
      end else if (ar_idx == `RTT_IDX_STATUS) begin
        // live timer activity
        next_s.rdata[3:0] = {rx_ignore, nr_busy, pw_busy, dly_busy};
      end else begin
        next_s.rresp = `RTT_RESP_SLVERR;
      end
    end
    // read data taken
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
      s.proto <= `RTT_PROTO_RST;
      s.tm_hi <= `RTT_TMHI_RST;
      s.tm_lo <= `RTT_TMLO_RST;
      s.pw <= `RTT_PW_RST;
      s.nr <= `RTT_NR_RST;
      s.ign <= `RTT_IGN_RST;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from state flops
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;
  assign protocol_sel = s.proto;
  assign tx_pulse = s.tx_pulse;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------

  AST_HIGH_BYTE_RESET: assert property (@(posedge clk)
    srst |=> (s.tm_hi == 8'hC2 && s.tm_lo == 8'h00))
    else $error("timer high byte not C2 after reset");

  AST_PROTO_WRITE_CLEARS: assert property (@(posedge clk) disable iff (srst)
    (proto_wr && s.en_s2) |=> (s.tm_hi == 8'hC2 && s.tm_lo == 8'h00
      && !dly_busy && !rx_ignore))
    else $error("protocol write did not reload timing");

  AST_START_SELECT: assert property (@(posedge clk) disable iff (srst)
    (s.tm_hi[7:6] == 2'h1 && tx_sof_end && dly_count != 14'h0000 && !clear_all)
      |=> dly_busy)
    else $error("selected start event did not start delay");

  AST_NOREPLY_DEFAULT: assert property (@(posedge clk) disable iff (srst)
    !s.en_s2 |=> (s.nr == 8'h0E && s.pw == 8'h00))
    else $error("no reply register not at default while disabled");

  AST_IGNORE_DEFAULT: assert property (@(posedge clk)
    srst |=> s.ign == 8'h1F)
    else $error("ignore register not at default");

  AST_IGNORE_OPENS: assert property (@(posedge clk) disable iff (srst)
    (tx_eof_end && s.ign != 8'h00 && !clear_all) |=> rx_ignore[*2])
    else $error("receive ignore window did not open");

  AST_REPLY_CANCELS: assert property (@(posedge clk) disable iff (srst)
    (rx_response_start && !tx_eof_end) |=> (!nr_busy ##1 !no_reply_irq))
    else $error("no reply timer survived a response");

  AST_PULSE_BYPASS: assert property (@(posedge clk) disable iff (srst)
    (s.pw == 8'h00) |=> (tx_pulse == $past(tx_pulse_req)))
    else $error("zero width did not pass the request");

  AST_PULSE_SHAPED: assert property (@(posedge clk) disable iff (srst)
    (s.pw == 8'h01 && tx_pulse_req && !pw_busy && !clear_all)
      |=> ##1 tx_pulse[*3] ##1 !tx_pulse)
    else $error("one step pulse not three cycles");

  AST_DELAY_LAUNCH: assert property (@(posedge clk) disable iff (srst)
    (dly_start && dly_count == 14'h0001 && !clear_all)
      |=> (!tx_delay_go && dly_busy)[*8] ##22 tx_delay_go)
    else $error("one step delay did not expire after 29 cycles");

endmodule // rtt_timing_top

// ==== verification/rtt_host_model.sv ====
// Purpose: host side register master for the timing timers
// Assumes: AXI4-Lite, one word per register, byte address = 4 * index
// Notes: released address and data lines show the inverse value
`timescale 1ns/1ps

module rtt_host_model (
  input wire logic clk,
  output logic [5:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  output logic [5:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  output logic rready
);
  // ---------------------------------------------
  // idle bus at time zero
  // ---------------------------------------------
  initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;

  // one write: address and data offered together, held until taken
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    logic a;
    logic w;
    logic b;
    // local flags: the driven lines only update after this time step
    a = 1'b1;
    w = 1'b1;
    b = 1'b1;
    @(posedge clk);
    awaddr <= {i, 2'h0};
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (a || w || b) begin
      @(posedge clk);
      // released lines must not keep the last value
      if (awready && a) begin
        a = 1'b0;
        awvalid <= 1'b0;
        awaddr <= ~awaddr;
      end
      if (wready && w) begin
        w = 1'b0;
        wvalid <= 1'b0;
        wdata <= ~wdata;
      end
      if (bvalid && b) begin
        b = 1'b0;
        bready <= 1'b0;
      end
    end
  endtask

  // one read: rready held until rvalid is sampled
  task automatic rd(input logic [3:0] i);
    logic a;
    logic r;
    a = 1'b1;
    r = 1'b1;
    @(posedge clk);
    araddr <= {i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (a || r) begin
      @(posedge clk);
      if (arready && a) begin
        a = 1'b0;
        arvalid <= 1'b0;
        araddr <= ~araddr;
      end
      if (rvalid && r) begin
        r = 1'b0;
        rready <= 1'b0;
      end
    end
  endtask
endmodule // rtt_host_model

// ==== verification/test_rfid_tx_rx_timing_timers.sv ====
// Purpose: self-checking bench for the timing timers
// Assumes: step cycles delay 29, pulse 3, no-reply 1888, ignore 472
// Notes: reads are checked from a queue of expected words
`timescale 1ns/1ps

module test_rfid_tx_rx_timing_timers;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic en = 1'b1;
  logic [6:0] ev = 7'h00; // event pulses, one bit each
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic tx_delay_go, tx_pulse, no_reply_irq, rx_ignore;
  logic [3:0] obs;
  logic [4:0] proto_pin; // protocol selection output
  logic [33:0] exp_q[$]; // expected {rresp, rdata}
  logic [31:0] tbl[6];
  int err_count = 0;
  int n_tests = 0;
  int n;
  logic [7:0] r;
  assign obs = {tx_pulse, rx_ignore, no_reply_irq, tx_delay_go};

  // ---------------------------------------------
  // clock, design and host
  // ---------------------------------------------
  initial forever #10 clk = ~clk;

  rtt_timing_top u_rtt_timing_top (.clk(clk), .srst(srst), .en(en),
    .tx_sof_begin(ev[0]), .tx_sof_end(ev[1]), .rx_sof_begin(ev[2]), .rx_sof_end(ev[3]),
    .tx_eof_end(ev[4]), .rx_response_start(ev[5]), .tx_pulse_req(ev[6]),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .protocol_sel(proto_pin), .tx_delay_go(tx_delay_go), .tx_pulse(tx_pulse),
    .no_reply_irq(no_reply_irq), .rx_ignore(rx_ignore));

  rtt_host_model u_rtt_host_model (.clk(clk), .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid), .awready(s_axi_awready), .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb), .wvalid(s_axi_wvalid), .wready(s_axi_wready),
    .bvalid(s_axi_bvalid), .bready(s_axi_bready), .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid), .arready(s_axi_arready), .rvalid(s_axi_rvalid),
    .rready(s_axi_rready));

  // ---------------------------------------------
  // checking helpers
  // ---------------------------------------------
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] e);
    n_tests++;
    if (seen !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, seen);
    end
  endtask

  // read answers are compared against the oldest note
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready) chk("read", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  end

  // every write in the scenarios targets a mapped register
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready) chk("bresp", {32'h0, s_axi_bresp}, 34'h0);
  end

  task automatic rd(input logic [3:0] i, input logic [33:0] e);
    exp_q.push_back(e);
    u_rtt_host_model.rd(i);
  endtask

  // one-cycle pulse on event bit b
  task automatic fire(input int b);
    @(posedge clk);
    ev <= 7'h01 << b;
    @(posedge clk);
    ev <= 7'h00;
  endtask

  // cycles until obs[s] is seen high, capped at lim
  task automatic cnt(input int s, output int k, input int lim);
    k = 0;
    while (!obs[s] && k < lim) begin
      @(posedge clk);
      k++;
    end
  endtask

  // length of the next high period of obs[s]
  task automatic hi_len(input int s, output int k);
    int w;
    w = 0;
    k = 0;
    while (!obs[s] && w < 100) begin
      @(posedge clk);
      w++;
    end
    while (obs[s] && k < 20000) begin
      @(posedge clk);
      k++;
    end
  endtask

  task automatic test_done();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  initial begin
    tbl = '{32'h0280141F, 32'h08200E07, 32'h09130E07, 32'h0A0A0E07, 32'h0B060E07, 32'h13951013};
    void'($urandom(32'h0F02));
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd(4'h4, 34'hC2); // preset high byte
    rd(4'h5, 34'h00); // preset low byte
    rd(4'h6, 34'h00); // preset pulse
    rd(4'h7, 34'h0E); // preset timeout
    rd(4'h8, 34'h1F); // preset ignore
    rd(4'h2, 34'h200000000); // unmapped word
    r = 8'($urandom_range(1, 255));
    u_rtt_host_model.wr(4'h6, r);
    rd(4'h6, {26'h0, r}); // stored width
    for (int i = 0; i < 6; i++) begin
      u_rtt_host_model.wr(4'h4, 8'h3F);
      u_rtt_host_model.wr(4'h1, tbl[i][31:24]);
      chk("proto pin", {29'h0, proto_pin}, 34'(tbl[i][28:24])); // code on pin
      rd(4'h1, {26'h0, tbl[i][31:24]}); // code stored
      rd(4'h4, 34'hC2); // reload on write
      rd(4'h6, {26'h0, tbl[i][23:16]}); // pulse preset
      rd(4'h7, {26'h0, tbl[i][15:8]}); // timeout preset
      rd(4'h8, {26'h0, tbl[i][7:0]}); // ignore preset
    end
    for (int s = 0; s < 4; s++) begin
      r = (s == 0) ? 8'h01 : 8'($urandom_range(1, 3));
      u_rtt_host_model.wr(4'h5, r);
      u_rtt_host_model.wr(4'h4, {2'(s), 6'h00});
      fire((s + 1) % 4);
      cnt(0, n, 120);
      chk("other start", 34'(n), 34'd120); // wrong event
      fire(s);
      cnt(0, n, 200);
      chk("delay", 34'(n), 34'(r * 29 + 1)); // delay length
    end
    u_rtt_host_model.wr(4'h4, 8'h01);
    u_rtt_host_model.wr(4'h5, 8'h00);
    fire(0);
    cnt(0, n, 9000);
    chk("delay hi", 34'(n), 34'd7425); // high bits count
    u_rtt_host_model.wr(4'h4, 8'h00);
    fire(0);
    cnt(0, n, 100);
    chk("zero delay", 34'(n), 34'd100); // disabled timer
    u_rtt_host_model.wr(4'h6, 8'h01);
    fire(6);
    hi_len(3, n);
    chk("pulse one", 34'(n), 34'd3); // one step pulse
    u_rtt_host_model.wr(4'h6, 8'h03);
    fire(6);
    hi_len(3, n);
    chk("pulse", 34'(n), 34'd9); // pulse length
    u_rtt_host_model.wr(4'h6, 8'h00);
    fire(6);
    hi_len(3, n);
    chk("pulse off", 34'(n), 34'd1); // shaping bypass
    // short ignore window first, so it has closed before its own test
    u_rtt_host_model.wr(4'h8, 8'h02);
    u_rtt_host_model.wr(4'h7, 8'h01);
    fire(4);
    cnt(1, n, 3000);
    chk("no reply", 34'(n), 34'd1889); // timeout interrupt
    fire(4);
    fire(5);
    cnt(1, n, 2500);
    chk("cancelled", 34'(n), 34'd2500); // response cancels
    fire(4);
    hi_len(2, n);
    chk("ignore", 34'(n), 34'd944); // ignore window
    u_rtt_host_model.wr(4'h5, 8'h55);
    en <= 1'b0;
    repeat (4) @(posedge clk);
    en <= 1'b1;
    repeat (4) @(posedge clk);
    rd(4'h5, 34'h00); // enable low clears
    chk("proto pin", {29'h0, proto_pin}, 34'h02); // default protocol
    repeat (5) @(posedge clk);
    test_done();
  end

  // hang guard
  initial begin
    repeat (80000) @(posedge clk);
    err_count++;
    test_done();
  end
endmodule // test_rfid_tx_rx_timing_timers
